/* hw/ict_pkg.sv */
// Purpose: constants and types for the instruction cycle timing core
// Assumes: one clock, synchronous active-low reset
// Notes:   instruction word is 16 bits, opcode class in the top nibble
//
// Function
// RL1: one instruction cycle is exactly four system clocks; all sequencing uses it
// RL2: most instructions take one cycle; branch, call and table read take two
// RL3: jump, call, return, interrupt return and table read add one cycle
// RL4: writing the program counter low byte redirects and costs one cycle
// RL5: skip test costs one cycle, plus one when the next instruction is skipped
// RL6: conditional skips test a data byte or one bit of it
// RL7: call saves the return point, return resumes after the call, jump saves none
// RL8: add and subtract give carry or borrow beyond 255 or below 0
// RL9: increment and decrement change the operand by exactly one
// RL10: logic and complement set the zero flag when the result is zero
// RL11: rotates shift by one; through-carry variants swap bit and carry
// RL12: bit set and clear change only the selected bit via internal rmw
// RL13: table reads fetch fixed data from a program memory region
// RL14: redirect discards the prefetched sequential instruction, forming the extra cycle
package ict_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLKS_PER_CYCLE = 4;
    localparam int unsigned PC_W           = 12;
    localparam int unsigned DM_AW          = 8;
    localparam int unsigned STACK_DEPTH    = 8;
    localparam logic [PC_W-1:0] PC_RST     = 12'h000;

    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    localparam int unsigned OP_HI  = 15;
    localparam int unsigned OP_LO  = 12;
    localparam int unsigned SUB_HI = 11;
    localparam int unsigned SUB_LO = 8;
    localparam int unsigned BIT_HI = 10;
    localparam int unsigned BIT_LO = 8;
    localparam logic [DM_AW-1:0] PCL_ADDR = 8'h02;

    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_ALU   = 4'h1,
        OP_MOVI  = 4'h2,
        OP_BSET  = 4'h3,
        OP_BCLR  = 4'h4,
        OP_SKZ   = 4'h5,
        OP_SKBZ  = 4'h6,
        OP_JUMP  = 4'h7,
        OP_CALL  = 4'h8,
        OP_RET   = 4'h9,
        OP_INTERRUPT_RETURN  = 4'ha,
        OP_TABRD = 4'hb,
        OP_STORE = 4'hc
    } ict_op_t;

    typedef enum logic [3:0] {
        ALU_ADD  = 4'h0,
        ALU_SUB  = 4'h1,
        ALU_AND  = 4'h2,
        ALU_OR   = 4'h3,
        ALU_XOR  = 4'h4,
        ALU_CPL  = 4'h5,
        ALU_INC  = 4'h6,
        ALU_DEC  = 4'h7,
        ALU_RR   = 4'h8,
        ALU_RL   = 4'h9,
        ALU_RRC  = 4'ha,
        ALU_RLC  = 4'hb,
        ALU_MOV  = 4'hc
    } ict_alu_t;

endpackage : ict_pkg

/* hw/ict_dmem.sv */
// Purpose: data memory with registered read and one write port
// Assumes: write and read happen in different phases of a cycle
// Notes:   read data come out of a register
`timescale 1ns/1ps
module ict_dmem
    import ict_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [DM_AW-1:0] waddr,
    input  wire logic [7:0]       wdata,
    input  wire logic [DM_AW-1:0] raddr,
    output logic      [7:0]       rdata_q
);
    logic [7:0] mem [2**DM_AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end
endmodule : ict_dmem

/* hw/ict_alu.sv */
// Purpose: 8-bit combinational arithmetic, logic and rotate unit
// Assumes: operands are stable during the execute phase
// Notes:   zero flag is produced for every result, used by caller
`timescale 1ns/1ps
module ict_alu
    import ict_pkg::*;
(
    input  wire logic [3:0] func,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] opnd,
    input  wire logic       cin,
    output logic      [7:0] res,
    output logic            cout,
    output logic            zero
);
    logic [8:0] sum;

    always_comb begin
        sum  = 9'h000;
        res  = opnd;
        cout = cin;
        case (ict_alu_t'(func))
            ALU_ADD: begin
                sum  = {1'b0, acc} + {1'b0, opnd};      // [RL8]
                res  = sum[7:0];
                cout = sum[8];
            end
            ALU_SUB: begin
                sum  = {1'b0, acc} - {1'b0, opnd};      // [RL8]
                res  = sum[7:0];
                cout = ~sum[8];                         // borrow: clear
            end
            ALU_AND: res = acc & opnd;
            ALU_OR:  res = acc | opnd;
            ALU_XOR: res = acc ^ opnd;
            ALU_CPL: res = ~opnd;
            ALU_INC: res = opnd + 8'h01;                // [RL9]
            ALU_DEC: res = opnd - 8'h01;                // [RL9]
            ALU_RR:  res = {opnd[0], opnd[7:1]};        // [RL11]
            ALU_RL:  res = {opnd[6:0], opnd[7]};        // [RL11]
            ALU_RRC: begin
                res  = {cin, opnd[7:1]};                // [RL11]
                cout = opnd[0];
            end
            ALU_RLC: begin
                res  = {opnd[6:0], cin};                // [RL11]
                cout = opnd[7];
            end
            ALU_MOV: res = opnd;
            default: res = opnd;
        endcase
        zero = (res == 8'h00);                          // [RL10]
    end
endmodule : ict_alu

/* hw/ict_core.sv */
// Purpose: fetch/execute sequencer of a small 8-bit core
// Assumes: program memory answers combinationally on prog_addr
// Notes:   one instruction cycle is four clocks, phases 0..3
`timescale 1ns/1ps
module ict_core
    import ict_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            nrst,
    output logic      [PC_W-1:0] prog_addr,
    input  wire logic [15:0]     prog_data,
    output logic      [7:0]      acc_q,
    output logic                 zero_q,
    output logic                 carry_q,
    output logic      [PC_W-1:0] pc_q,
    output logic                 cycle_end,
    output logic                 flush_q,
    output logic      [7:0]      tbl_data_q
);
    // ------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------
    logic [1:0] phase_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;                  // [RL1]
        end
    end

    assign cycle_end = (phase_q == 2'(CLKS_PER_CYCLE - 1)); // [RL1]

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic redirects(input logic [15:0] iw);
        ict_op_t op;
        op = ict_op_t'(iw[OP_HI:OP_LO]);
        return (op == OP_JUMP) || (op == OP_CALL) ||
               (op == OP_RET)  || (op == OP_INTERRUPT_RETURN);
    endfunction : redirects

    function automatic logic writes_mem(input logic [15:0] iw);
        ict_op_t op;
        op = ict_op_t'(iw[OP_HI:OP_LO]);
        // arithmetic always lands in the accumulator: the function field
        // takes all of bits 11..8, so no destination bit is left over
        return (op == OP_STORE) || (op == OP_BSET) || (op == OP_BCLR);
    endfunction : writes_mem

    // ------------------------------------------------------------
    // pipeline: fetch register and execute register
    // ------------------------------------------------------------
    logic [15:0]     ir_q;
    logic [PC_W-1:0] ret_q [STACK_DEPTH];
    logic [2:0]      sp_q;
    logic            tbl_pend_q;

    ict_op_t         op;
    logic [7:0]      maddr;
    logic [7:0]      mdata;
    logic [7:0]      alu_res;
    logic            alu_c;
    logic            alu_z;
    logic [7:0]      bit_res;
    logic            skip;
    logic            pcl_wr;
    logic            redirect;
    logic [PC_W-1:0] target;
    logic            mem_we;
    logic [7:0]      mem_wd;
    logic [2:0]      bsel;

    assign op    = ict_op_t'(ir_q[OP_HI:OP_LO]);
    assign maddr = ir_q[7:0];
    assign bsel  = ir_q[BIT_HI:BIT_LO];

    ict_dmem u_dmem (
        .clk     (clk),
        .we      (mem_we),
        .waddr   (maddr),
        .wdata   (mem_wd),
        .raddr   (maddr),
        .rdata_q (mdata)
    );

    ict_alu u_alu (
        .func (ir_q[SUB_HI:SUB_LO]),
        .acc  (acc_q),
        .opnd (mdata),
        .cin  (carry_q),
        .res  (alu_res),
        .cout (alu_c),
        .zero (alu_z)
    );

    // only the chosen bit moves; the others come back from the read
    always_comb begin
        bit_res       = mdata;                          // [RL12]
        bit_res[bsel] = (op == OP_BSET);                // [RL12]
    end

    always_comb begin
        skip = 1'b0;
        case (op)
            OP_SKZ:  skip = (mdata == 8'h00);           // [RL6]
            OP_SKBZ: skip = ~mdata[bsel];               // [RL6]
            default: skip = 1'b0;
        endcase
    end

    always_comb begin
        mem_wd = alu_res;
        case (op)
            OP_STORE: mem_wd = acc_q;
            OP_BSET:  mem_wd = bit_res;
            OP_BCLR:  mem_wd = bit_res;
            default:  mem_wd = alu_res;
        endcase
    end

    // memory write lands in phase 2 after the registered read in phase 1
    assign mem_we = (phase_q == 2'h2) && writes_mem(ir_q) && !flush_q &&
                    (maddr != PCL_ADDR);

    assign pcl_wr = writes_mem(ir_q) && (maddr == PCL_ADDR);       // [RL4]

    always_comb begin
        target = pc_q;
        if (pcl_wr) begin
            target = {pc_q[PC_W-1:8], mem_wd};                      // [RL4]
        end else begin
            case (op)
                OP_JUMP: target = ir_q[PC_W-1:0];                   // [RL3]
                OP_CALL: target = ir_q[PC_W-1:0];                   // [RL3]
                OP_RET:  target = ret_q[sp_q - 3'h1];               // [RL7]
                OP_INTERRUPT_RETURN: target = ret_q[sp_q - 3'h1];               // [RL7]
                default: target = pc_q;
            endcase
        end
    end

    // any non-sequential move, a taken skip or a table read costs one
    // extra cycle: the prefetched word is thrown away, or held back
    // while the table word is fetched
    assign redirect = !flush_q &&
                      (redirects(ir_q) || pcl_wr || skip ||
                       (op == OP_TABRD));                           // [RL2]

    // ------------------------------------------------------------
    // fetch and program counter
    // ------------------------------------------------------------
    always_comb begin
        prog_addr = pc_q;
        if (tbl_pend_q) begin
            prog_addr = {{(PC_W-8){1'b0}}, acc_q};                  // [RL13]
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc_q    <= PC_RST;
            ir_q    <= 16'h0000;
            flush_q <= 1'b0;
        end else if (cycle_end) begin
            if (tbl_pend_q) begin
                // the word fetched behind the table read waits in ir_q
                pc_q <= pc_q;                                       // [RL13]
            end else if (redirect && (op != OP_TABRD) && !skip) begin
                pc_q <= target;                                     // [RL14]
                ir_q <= 16'h0000;                                   // [RL14]
            end else if (redirect && (op != OP_TABRD)) begin
                // taken skip: drop the prefetched word and step past it
                pc_q <= pc_q + 12'h001;                             // [RL5]
                ir_q <= 16'h0000;                                   // [RL5]
            end else begin
                pc_q <= pc_q + 12'h001;
                ir_q <= prog_data;
            end
            flush_q <= redirect;                                    // [RL5]
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sp_q <= 3'h0;
        end else if (cycle_end && !flush_q) begin
            case (op)
                OP_CALL: begin
                    // pc already points at the word after the call
                    ret_q[sp_q] <= pc_q;                            // [RL7]
                    sp_q        <= sp_q + 3'h1;
                end
                OP_RET:  sp_q <= sp_q - 3'h1;                       // [RL7]
                OP_INTERRUPT_RETURN: sp_q <= sp_q - 3'h1;                       // [RL7]
                default: sp_q <= sp_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // table read: second cycle drives the table address
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tbl_pend_q <= 1'b0;
            tbl_data_q <= 8'h00;
        end else if (cycle_end) begin
            tbl_pend_q <= !flush_q && (op == OP_TABRD);             // [RL13]
            if (tbl_pend_q) begin
                tbl_data_q <= prog_data[7:0];                       // [RL13]
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc_q   <= 8'h00;
            zero_q  <= 1'b0;
            carry_q <= 1'b0;
        end else if (cycle_end && !flush_q) begin
            case (op)
                OP_ALU: begin
                    acc_q <= alu_res;
                    // rotates and moves leave the zero flag alone
                    if (!ir_q[SUB_HI]) begin
                        zero_q <= alu_z;                            // [RL10]
                    end
                    carry_q <= alu_c;                               // [RL8]
                end
                OP_MOVI: acc_q <= ir_q[7:0];
                default: acc_q <= acc_q;
            endcase
        end
    end
endmodule : ict_core

/* testbench/ict_core_monitor.sv */
// Purpose: port-level timing checks on the instruction cycle core
// Assumes: a discarded fetch shows as flush_q in the following cycle
// Notes:   bound to ict_core
`timescale 1ns/1ps
module ict_chk_monitor
    import ict_pkg::*;
(
    input wire logic            clk,
    input wire logic            nrst,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [15:0]     prog_data,
    input wire logic [7:0]      acc_q,
    input wire logic            zero_q,
    input wire logic            carry_q,
    input wire logic [PC_W-1:0] pc_q,
    input wire logic            cycle_end,
    input wire logic            flush_q,
    input wire logic [7:0]      tbl_data_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // a fetch only counts if the next cycle is not a flush
    sequence fetch_s(logic [3:0] op);
        cycle_end && prog_data[15:12] == op ##1 !flush_q;
    endsequence

    chk_cycle_period: assert property (
        cycle_end |=> !cycle_end [*3] ##1 cycle_end)
        else $error("cycle end not every four clocks");
    chk_state_hold: assert property (
        !cycle_end |=> $stable({acc_q, zero_q, carry_q, tbl_data_q, pc_q}))
        else $error("state moved inside an instruction cycle");
    chk_flush_len: assert property (
        $rose(flush_q) |-> flush_q [*4] ##1 !flush_q)
        else $error("flush not exactly one cycle");
    chk_flush_align: assert property (
        $rose(flush_q) |-> $past(cycle_end))
        else $error("flush started off a cycle boundary");
    chk_flush_nop: assert property (
        cycle_end && flush_q |=> $stable({acc_q, zero_q, carry_q}))
        else $error("discarded cycle changed state");
    chk_tbl_hold: assert property (
        cycle_end && !flush_q |=> $stable(tbl_data_q))
        else $error("table byte moved outside a table cycle");
    chk_jump_target: assert property (
        fetch_s(4'h7) |-> ##3 cycle_end
            ##1 flush_q && pc_q == $past(prog_data[11:0], 5))
        else $error("jump target or extra cycle wrong");
    chk_call_target: assert property (
        fetch_s(4'h8) |-> ##3 cycle_end
            ##1 flush_q && pc_q == $past(prog_data[11:0], 5))
        else $error("call target or extra cycle wrong");
    chk_movi_value: assert property (
        fetch_s(4'h2) |-> ##3 cycle_end ##1 acc_q == $past(prog_data[7:0], 5))
        else $error("immediate not loaded one cycle later");
    chk_zero_flag: assert property (
        cycle_end && prog_data[15:11] == 5'b00010 ##1 !flush_q
            |-> ##3 cycle_end ##1 zero_q == (acc_q == 8'h00))
        else $error("zero flag disagrees with result");

    cover property (fetch_s(4'h7));
    cover property (fetch_s(4'hb));
    cover property ($rose(flush_q));
endmodule : ict_chk_monitor

bind ict_core ict_chk_monitor ict_chk_monitor_inst (
    .clk(clk), .nrst(nrst), .prog_addr(prog_addr), .prog_data(prog_data),
    .acc_q(acc_q), .zero_q(zero_q), .carry_q(carry_q), .pc_q(pc_q),
    .cycle_end(cycle_end), .flush_q(flush_q), .tbl_data_q(tbl_data_q)
);

/* testbench/instruction_cycle_timing_test.sv */
// Purpose: self-checking bench for the instruction cycle core
// Assumes: program memory lives here and answers at the falling edge
// Notes:   a reference model predicts state at every cycle end
`timescale 1ns/1ps
module instruction_cycle_timing_test;
    import ict_pkg::*;

    logic            clk;
    logic            nrst;
    logic [PC_W-1:0] prog_addr;
    logic [15:0]     prog_data;
    logic [7:0]      acc_q;
    logic            zero_q;
    logic            carry_q;
    logic [PC_W-1:0] pc_q;
    logic            cycle_end;
    logic            flush_q;
    logic [7:0]      tbl_data_q;
    logic [15:0]     rom [4096];
    logic [18:0]     exp_q [$];
    logic [18:0]     e;
    logic [31:0]     seed;
    int              err_count = 0;
    int              cmp_count = 0;
    int              cyc = 0;
    // words 0 and 2 get random immediates; 0x16 and 0x1f must be dropped
    logic [15:0]     prg [32] = '{
        16'h2000, 16'hc010, 16'h2000, 16'h1010, 16'h1110, 16'hc011, 16'h1211,
        16'h1311, 16'h1411, 16'h1511, 16'h1611, 16'h1711, 16'h1811, 16'h1911,
        16'h1a11, 16'h1b11, 16'h3511, 16'h4011, 16'h1c11, 16'h2000, 16'hc012,
        16'h5012, 16'h20ff, 16'h5010, 16'h6711, 16'h2005, 16'h8030, 16'h2040,
        16'hb000, 16'h2020, 16'hc002, 16'h20ee};

    ict_core ict_core_inst (
        .clk(clk), .nrst(nrst), .prog_addr(prog_addr), .prog_data(prog_data),
        .acc_q(acc_q), .zero_q(zero_q), .carry_q(carry_q), .pc_q(pc_q),
        .cycle_end(cycle_end), .flush_q(flush_q), .tbl_data_q(tbl_data_q)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic report_and_stop();
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [18:0] x);
        logic [18:0] got;
        got = {flush_q, tbl_data_q, carry_q, zero_q, acc_q};
        cmp_count++;
        if (got !== x) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, x);
        end
    endtask : check

    // ----------------------------------------------------------------
    // reference model: one entry per cycle end, flush cycles included
    // ----------------------------------------------------------------
    task automatic run_model();
        logic [11:0] pc;
        logic [11:0] stk [$];
        logic [7:0]  mem [256];
        logic [15:0] w;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  t;
        logic [7:0]  nt;
        logic        c;
        logic        z;
        logic        rd;
        pc = 12'h000;
        {a, t, c, z} = 18'h00000;
        repeat (2) exp_q.push_back(19'h00000);
        repeat (45) begin
            w = rom[pc];
            pc = pc + 12'h001;
            b = mem[w[7:0]];
            rd = 1'b0;
            nt = t;
            case (w[15:12])
                4'h1: begin
                    case (w[11:8])
                        4'h0: {c, a} = {1'b0, a} + {1'b0, b};
                        4'h1: {c, a} = {a >= b, a - b};
                        4'h2: a = a & b;
                        4'h3: a = a | b;
                        4'h4: a = a ^ b;
                        4'h5: a = ~b;
                        4'h6: a = b + 8'h01;
                        4'h7: a = b - 8'h01;
                        4'h8: a = {b[0], b[7:1]};
                        4'h9: a = {b[6:0], b[7]};
                        4'ha: {a, c} = {c, b};
                        4'hb: {c, a} = {b, c};
                        default: a = b;
                    endcase
                    if (!w[11]) z = (a == 8'h00);
                end
                4'h2: a = w[7:0];
                4'h3: mem[w[7:0]][w[10:8]] = 1'b1;
                4'h4: mem[w[7:0]][w[10:8]] = 1'b0;
                4'h5: rd = (b == 8'h00);
                4'h6: rd = !b[w[10:8]];
                4'h8: stk.push_back(pc);
                4'h9, 4'ha: pc = stk.pop_back();
                4'hb: nt = rom[{4'h0, a}][7:0];
                4'hc: begin
                    if (w[7:0] == PCL_ADDR) begin
                        pc = {pc[11:8], a};
                        rd = 1'b1;
                    end else begin
                        mem[w[7:0]] = a;
                    end
                end
                default: ;
            endcase
            if (w[15:12] == 4'h5 || w[15:12] == 4'h6) pc = pc + {11'h0, rd};
            if (w[15:12] == 4'h7 || w[15:12] == 4'h8) pc = w[11:0];
            if (w[15:12] inside {[4'h7:4'hb]}) rd = 1'b1;
            exp_q.push_back({rd, t, c, z, a});
            t = nt;
            if (rd) exp_q.push_back({1'b0, t, c, z, a});
        end
    endtask : run_model

    always @(negedge clk) begin
        prog_data <= rom[prog_addr];
        if (nrst === 1'b1 && cycle_end === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(e);
        end
    end

    // hang guard: the program needs about 300 clocks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        nrst = 1'b0;
        prog_data = 16'h0000;
        seed = xs(32'h2bf9857b);
        foreach (rom[i]) rom[i] = 16'h0000;
        foreach (prg[i]) rom[i] = prg[i];
        rom[0][7:0] = seed[7:0];
        seed = xs(seed);
        rom[2][7:0] = seed[15:8];
        rom[12'h020] = 16'h7020;
        rom[12'h030] = 16'h1610;
        rom[12'h031] = 16'h8034;
        rom[12'h032] = 16'h9000;
        rom[12'h034] = 16'ha000;
        rom[12'h040] = 16'h00a5;
        run_model();
        repeat (10) @(negedge clk);
        nrst <= 1'b1;
        wait (exp_q.size() == 0);
        report_and_stop();
    end
endmodule : instruction_cycle_timing_test
